// [core_exec_pkg.sv]
package core_exec_pkg;

  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W    = 11;
  localparam int JUMP_W  = 9;
  localparam int FILE_DEPTH = 32;

  // instruction word and status register fields
  localparam int DEST_BIT = 5;
  localparam int PAGE_LO  = 5;
  localparam int PAGE_HI  = 6;
  localparam int ZERO_BIT = 2;

  // opcode masks and patterns
  localparam logic [INSTR_W-1:0] MASK_IDLE  = 12'hfff;
  localparam logic [INSTR_W-1:0] PAT_IDLE   = 12'h000;
  localparam logic [INSTR_W-1:0] MASK_STORE = 12'hfe0;
  localparam logic [INSTR_W-1:0] PAT_STORE  = 12'h020;
  localparam logic [INSTR_W-1:0] MASK_FDOP  = 12'hfc0;
  localparam logic [INSTR_W-1:0] PAT_ORF    = 12'h100;
  localparam logic [INSTR_W-1:0] PAT_COPY   = 12'h200;
  localparam logic [INSTR_W-1:0] PAT_INCSZ  = 12'h3c0;
  localparam logic [INSTR_W-1:0] MASK_JUMP  = 12'he00;
  localparam logic [INSTR_W-1:0] PAT_JUMP   = 12'ha00;
  localparam logic [INSTR_W-1:0] MASK_LIT   = 12'hf00;
  localparam logic [INSTR_W-1:0] PAT_LOADL  = 12'hc00;
  localparam logic [INSTR_W-1:0] PAT_ORL    = 12'hd00;

  // reset values
  localparam logic [PC_W-1:0]    PC_RESET     = 11'h000;
  localparam logic [DATA_W-1:0]  ACC_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]  STATUS_RESET = 8'h00;
  localparam logic [INSTR_W-1:0] IDLE_WORD    = 12'h000;

  typedef enum logic [2:0] {
    op_idle,
    op_store,
    op_or_file,
    op_copy,
    op_inc_skip,
    op_jump,
    op_load_lit,
    op_or_lit
  } op_t;

  function automatic logic op_match(input logic [INSTR_W-1:0] word,
                                    input logic [INSTR_W-1:0] mask,
                                    input logic [INSTR_W-1:0] pat);
    op_match = ((word & mask) == pat);
  endfunction

endpackage

// [file_regs.sv]
`timescale 1ns/1ps
module file_regs #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  wire              bypass = wr_en && (wr_addr == rd_addr);

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // write-first read so a back-to-back access sees the new value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= bypass ? wr_data : mem[rd_addr];
    end
  end

endmodule

// [op_decoder.sv]
`timescale 1ns/1ps
module op_decoder
(
  input  wire logic [core_exec_pkg::INSTR_W-1:0] word,
  output core_exec_pkg::op_t                     op,
  output logic      [core_exec_pkg::FADDR_W-1:0] faddr,
  output logic                                   dest_file,
  output logic      [core_exec_pkg::DATA_W-1:0]  literal,
  output logic      [core_exec_pkg::JUMP_W-1:0]  target
);

  import core_exec_pkg::*;

  wire is_store = op_match(word, MASK_STORE, PAT_STORE);
  wire is_orf   = op_match(word, MASK_FDOP, PAT_ORF);
  wire is_copy  = op_match(word, MASK_FDOP, PAT_COPY);
  wire is_incsz = op_match(word, MASK_FDOP, PAT_INCSZ);
  wire is_jump  = op_match(word, MASK_JUMP, PAT_JUMP);
  wire is_loadl = op_match(word, MASK_LIT, PAT_LOADL);
  wire is_orl   = op_match(word, MASK_LIT, PAT_ORL);

  // anything outside the subset runs as an idle cycle
  assign op = is_store ? op_store :
              is_orf   ? op_or_file :
              is_copy  ? op_copy :
              is_incsz ? op_inc_skip :
              is_jump  ? op_jump :
              is_loadl ? op_load_lit :
              is_orl   ? op_or_lit : op_idle;

  assign faddr     = word[FADDR_W-1:0];
  assign dest_file = word[DEST_BIT];
  assign literal   = word[DATA_W-1:0];
  assign target    = word[JUMP_W-1:0];

endmodule

// [core_exec.sv]
// Overview of operation
// - destination bit 0 writes accumulator, 1 writes the addressed file register
// - increment-skip-zero adds one to file register, writes destination, flags untouched
// - zero increment result discards the fetched next word and idles one cycle
// - absolute jump loads its 9-bit operand into pointer bits 8:0
// - absolute jump loads pointer bits 10:9 from status bits 6:5
// - absolute jump takes two cycles and leaves status flags alone
// - or-literal ors accumulator with literal into accumulator, updates zero flag
// - or-file ors accumulator with file register into destination, updates zero flag
// - store copies accumulator into file register, flags untouched
// - copy-file moves file register to destination, zero flag from that value
// - copy-file with destination 1 rewrites the register and still updates zero
// - load-literal puts literal into accumulator, flags untouched
// - zero flag set when result is zero, cleared otherwise
`timescale 1ns/1ps
module core_exec
#(
  parameter int DATA_WIDTH = core_exec_pkg::DATA_W,
  parameter int FILE_COUNT = core_exec_pkg::FILE_DEPTH
) (
  input  wire logic                                                  clk,
  input  wire logic                                                  rst,
  input  wire logic [core_exec_pkg::INSTR_W-1:0]                      instr,
  input  wire logic                                                  page_load,
  input  wire logic [core_exec_pkg::PAGE_HI-core_exec_pkg::PAGE_LO:0] page_value,
  output logic      [core_exec_pkg::PC_W-1:0]                         instruction_pointer,
  output logic      [core_exec_pkg::DATA_W-1:0]                       acc,
  output logic      [core_exec_pkg::DATA_W-1:0]                       status,
  output logic                                                       discard
);

  import core_exec_pkg::*;

  // execute stage
  logic [INSTR_W-1:0] exec_word;
  logic [DATA_W-1:0]  fdata;

  op_t                op;
  logic [FADDR_W-1:0] faddr;
  logic               dest_bit;
  logic [DATA_W-1:0]  literal;
  logic [JUMP_W-1:0]  target;

  op_decoder u_dec (
    .word      (exec_word),
    .op        (op),
    .faddr     (faddr),
    .dest_file (dest_bit),
    .literal   (literal),
    .target    (target)
  );

  // a discarded word behaves as an idle op
  wire live      = !discard;
  wire do_store  = live && (op == op_store);
  wire do_orf    = live && (op == op_or_file);
  wire do_copy   = live && (op == op_copy);
  wire do_inc    = live && (op == op_inc_skip);
  wire do_jump   = live && (op == op_jump);
  wire do_loadl  = live && (op == op_load_lit);
  wire do_orl    = live && (op == op_or_lit);
  wire do_idle   = discard || (op == op_idle);
  wire has_dest  = do_orf || do_copy || do_inc;

  wire [DATA_W-1:0] inc_sum  = fdata + 8'h01;
  wire [DATA_W-1:0] or_file  = acc | fdata;
  wire [DATA_W-1:0] or_lit   = acc | literal;

  wire [DATA_W-1:0] result = do_inc   ? inc_sum :
                             do_orf   ? or_file :
                             do_orl   ? or_lit :
                             do_loadl ? literal :
                             do_store ? acc : fdata;

  wire write_file = do_store || (has_dest && dest_bit);
  wire write_acc  = do_loadl || do_orl || (has_dest && !dest_bit);
  wire zero_upd   = do_orl || do_orf || do_copy;
  wire result_z   = (result == 8'h00);
  wire skip_taken = do_inc && (inc_sum == 8'h00);

  wire [PC_W-1:0] jump_dest = {status[PAGE_HI:PAGE_LO], target};
  wire [PC_W-1:0] next_pc   = do_jump ? jump_dest : instruction_pointer + 11'h001;
  wire            next_discard = do_jump || skip_taken;

  file_regs #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FILE_COUNT),
    .AW    (FADDR_W)
  ) u_files (
    .clk     (clk),
    .rst     (rst),
    .rd_addr (instr[FADDR_W-1:0]),
    .rd_data (fdata),
    .wr_en   (write_file),
    .wr_addr (faddr),
    .wr_data (result)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exec_word <= IDLE_WORD;
      discard   <= 1'b1;
    end
    else
    begin
      exec_word <= instr;
      discard   <= next_discard;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      instruction_pointer <= PC_RESET;
    end
    else
    begin
      instruction_pointer <= next_pc;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc <= ACC_RESET;
    end
    else if (write_acc)
    begin
      acc <= result;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      if (zero_upd)
      begin
        status[ZERO_BIT] <= result_z;
      end
      if (page_load)
      begin
        status[PAGE_HI:PAGE_LO] <= page_value;
      end
    end
  end

  // checks

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  sequence s_skip;
    skip_taken;
  endsequence

  sequence s_idle_after;
    discard ##1 (acc == $past(acc))
      && (instruction_pointer == $past(instruction_pointer) + 11'h001);
  endsequence

  sequence s_jump;
    do_jump && !page_load;
  endsequence

  a_dest_acc_sel: assert property (
    (has_dest && !dest_bit) |=> (acc == $past(result)) && !$past(write_file))
    else $error("destination 0 did not land in accumulator");

  a_dest_file_sel: assert property (
    (has_dest && dest_bit) |=> (u_files.mem[$past(faddr)] == $past(result))
      && (acc == $past(acc)))
    else $error("destination 1 did not write the file register");

  a_inc_value: assert property (
    (do_inc && !page_load) |-> (result == fdata + 8'h01)
      ##1 (status == $past(status)))
    else $error("increment wrong or flags touched");

  a_skip_discard: assert property (
    s_skip |=> s_idle_after)
    else $error("zero increment did not discard next word");

  a_no_false_skip: assert property (
    (do_inc && (fdata != 8'hff) && !do_jump) |=> !discard)
    else $error("skip without zero result");

  a_jump_target: assert property (
    do_jump |=> instruction_pointer[JUMP_W-1:0] == $past(target))
    else $error("jump low bits wrong");

  a_jump_page: assert property (
    do_jump |=> instruction_pointer[PC_W-1:JUMP_W] == $past(status[PAGE_HI:PAGE_LO]))
    else $error("jump page bits wrong");

  a_jump_two_cyc: assert property (
    s_jump |=> discard && (status == $past(status)) ##1 (acc == $past(acc)))
    else $error("jump not two cycles or flags changed");

  a_or_lit: assert property (
    do_orl |=> (acc == ($past(acc) | $past(literal)))
      && (status[ZERO_BIT] == (($past(acc) | $past(literal)) == 8'h00)))
    else $error("or literal wrong");

  a_or_file: assert property (
    do_orf |=> status[ZERO_BIT] == (($past(acc) | $past(fdata)) == 8'h00))
    else $error("or file zero flag wrong");

  a_store_acc: assert property (
    (do_store && !page_load) |-> write_file && (u_files.wr_data == acc)
      ##1 (status == $past(status)) && (acc == $past(acc)))
    else $error("store accumulator wrong");

  a_copy_zero: assert property (
    do_copy |=> status[ZERO_BIT] == ($past(fdata) == 8'h00))
    else $error("copy zero flag wrong");

  a_copy_test: assert property (
    (do_copy && dest_bit) |=> (u_files.mem[$past(faddr)] == $past(fdata))
      && (acc == $past(acc)))
    else $error("copy to self did not rewrite");

  a_load_lit: assert property (
    (do_loadl && !page_load) |=> (acc == $past(literal)) && (status == $past(status)))
    else $error("load literal wrong");

  a_idle_op: assert property (
    (do_idle && !page_load) |-> !write_file
      ##1 (acc == $past(acc)) && (status == $past(status))
      && (instruction_pointer == $past(instruction_pointer) + 11'h001))
    else $error("idle op changed state");

  a_pc_step: assert property (
    !do_jump |=> instruction_pointer == $past(instruction_pointer) + 11'h001)
    else $error("pointer did not step by one");

  a_orf_to_acc: assert property (
    (do_orf && !dest_bit) |=> acc == ($past(acc) | $past(fdata)))
    else $error("or file into accumulator wrong");

  a_orf_to_file: assert property (
    (do_orf && dest_bit) |=> (u_files.mem[$past(faddr)] == ($past(acc) | $past(fdata)))
      && (acc == $past(acc)))
    else $error("or file into register wrong");

  a_copy_to_acc: assert property (
    (do_copy && !dest_bit) |=> acc == $past(fdata))
    else $error("copy into accumulator wrong");

  a_store_lands: assert property (
    do_store |=> u_files.mem[$past(faddr)] == $past(acc))
    else $error("store did not reach the register");

  a_inc_to_acc: assert property (
    (do_inc && !dest_bit) |=> acc == $past(fdata) + 8'h01)
    else $error("increment into accumulator wrong");

  a_inc_to_file: assert property (
    (do_inc && dest_bit) |=> (u_files.mem[$past(faddr)] == $past(fdata) + 8'h01)
      && (acc == $past(acc)))
    else $error("increment into register wrong");

  a_zero_kept: assert property (
    (do_inc || do_store || do_loadl || do_jump || do_idle)
      |=> status[ZERO_BIT] == $past(status[ZERO_BIT]))
    else $error("zero flag moved on a flag free op");

  a_zero_follows: assert property (
    zero_upd |=> status[ZERO_BIT] == ($past(result) == 8'h00))
    else $error("zero flag does not follow result");

  a_page_kept: assert property (
    !page_load |=> status[PAGE_HI:PAGE_LO] == $past(status[PAGE_HI:PAGE_LO]))
    else $error("page bits moved without a load");

  a_discard_quiet: assert property (
    (discard && !page_load) |=> (acc == $past(acc)) && (status == $past(status)))
    else $error("discarded word changed state");

  a_discard_once: assert property (
    discard |=> !discard)
    else $error("more than one word discarded");

  a_single_cycle: assert property (
    (do_store || do_orf || do_copy || do_loadl || do_orl) |=> !discard)
    else $error("single cycle op discarded a word");

  a_acc_kept: assert property (
    (do_store || do_jump || (has_dest && dest_bit)) |=> acc == $past(acc))
    else $error("accumulator moved without a write");

  a_skip_pointer: assert property (
    s_skip |=> (instruction_pointer == $past(instruction_pointer) + 11'h001) ##1 !discard)
    else $error("skip did not step past the dropped word");

  a_jump_word_drop: assert property (
    s_jump |=> discard ##1 !discard
      && (instruction_pointer == $past(instruction_pointer) + 11'h001))
    else $error("jump did not drop exactly one word");

endmodule

// [prog_mem.sv]
`timescale 1ns/1ps
module prog_mem
(
  input  wire logic [core_exec_pkg::PC_W-1:0]    addr,
  output logic      [core_exec_pkg::INSTR_W-1:0] word
);
  import core_exec_pkg::*;

  logic [INSTR_W-1:0] rom [0:(1<<PC_W)-1];

  // combinational fetch at the pointer, as the core expects
  assign word = rom[addr];

  // unloaded places run as idle words
  task automatic clear();
    foreach (rom[i])
    begin
      rom[i] = IDLE_WORD;
    end
  endtask
endmodule

// [baseline_core_instr_exec_subset_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module baseline_core_instr_exec_subset_test;
  import core_exec_pkg::*;

  logic               clk;
  logic               rst;
  logic               page_load;
  logic [1:0]         page_value;
  logic [INSTR_W-1:0] instr;
  logic [PC_W-1:0]    ptr;
  logic [DATA_W-1:0]  acc;
  logic [DATA_W-1:0]  status;
  logic               discard;
  int                 n_mismatch;
  int                 num_checks;
  int                 cycles;

  core_exec uut (
    .clk                 (clk),
    .rst                 (rst),
    .instr               (instr),
    .page_load           (page_load),
    .page_value          (page_value),
    .instruction_pointer (ptr),
    .acc                 (acc),
    .status              (status),
    .discard             (discard)
  );

  prog_mem mem (
    .addr (ptr),
    .word (instr)
  );

  always #12.5 clk = ~clk;

  // runaway guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic start();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    `CHK("reset pointer", 11'h000, ptr)
    `CHK("reset discard", 1'b1, discard)
    rst = 1'b0;
    tick();
  endtask

  task automatic expect_state(input logic [DATA_W-1:0] ea, input logic [DATA_W-1:0] es,
                              input logic [PC_W-1:0] ep, input logic ed);
    tick();
    `CHK("acc", ea, acc)
    `CHK("status", es, status)
    `CHK("pointer", ep, ptr)
    `CHK("discard", ed, discard)
  endtask

  // literal ops and the zero flag
  task automatic test_literal();
    mem.clear();
    mem.rom[0] = 12'hc00;
    mem.rom[1] = 12'hd00;
    mem.rom[2] = 12'hc5a;
    mem.rom[3] = 12'hd81;
    start();
    expect_state(8'h00, 8'h00, 11'h002, 1'b0);
    expect_state(8'h00, 8'h04, 11'h003, 1'b0);
    expect_state(8'h5a, 8'h04, 11'h004, 1'b0);
    expect_state(8'hdb, 8'h00, 11'h005, 1'b0);
    expect_state(8'hdb, 8'h00, 11'h006, 1'b0);
  endtask

  // file register ops, destinations, taken and untaken skip
  task automatic test_files();
    logic [INSTR_W-1:0] p [13] = '{12'hcff, 12'h023, 12'h3e3, 12'hc11, 12'h203, 12'hc30,
                                  12'h123, 12'hc00, 12'h203, 12'hc00, 12'hd00, 12'h223,
                                  12'h3c3};
    mem.clear();
    foreach (p[i])
    begin
      mem.rom[i] = p[i];
    end
    start();
    expect_state(8'hff, 8'h00, 11'h002, 1'b0);
    expect_state(8'hff, 8'h00, 11'h003, 1'b0);
    expect_state(8'hff, 8'h00, 11'h004, 1'b1);
    expect_state(8'hff, 8'h00, 11'h005, 1'b0);
    expect_state(8'h00, 8'h04, 11'h006, 1'b0);
    expect_state(8'h30, 8'h04, 11'h007, 1'b0);
    expect_state(8'h30, 8'h00, 11'h008, 1'b0);
    expect_state(8'h00, 8'h00, 11'h009, 1'b0);
    expect_state(8'h30, 8'h00, 11'h00a, 1'b0);
    expect_state(8'h00, 8'h00, 11'h00b, 1'b0);
    expect_state(8'h00, 8'h04, 11'h00c, 1'b0);
    expect_state(8'h00, 8'h00, 11'h00d, 1'b0);
    expect_state(8'h31, 8'h00, 11'h00e, 1'b0);
    expect_state(8'h31, 8'h00, 11'h00f, 1'b0);
  endtask

  // jump to the top of a page, page bits from status
  task automatic test_jump();
    mem.clear();
    mem.rom[0] = 12'hc00;
    mem.rom[1] = 12'hd00;
    mem.rom[2] = 12'hbff;
    mem.rom[3] = 12'hc77;
    mem.rom[11'h5ff] = 12'hc42;
    start();
    page_value = 2'b10;
    page_load = 1'b1;
    expect_state(8'h00, 8'h40, 11'h002, 1'b0);
    page_load = 1'b0;
    expect_state(8'h00, 8'h44, 11'h003, 1'b0);
    expect_state(8'h00, 8'h44, 11'h5ff, 1'b1);
    expect_state(8'h00, 8'h44, 11'h600, 1'b0);
    expect_state(8'h42, 8'h44, 11'h601, 1'b0);
  endtask

  // accumulator destinations and a skip that writes the accumulator
  task automatic test_acc_dest();
    mem.clear();
    mem.rom[0] = 12'hcff;
    mem.rom[1] = 12'h021;
    mem.rom[2] = 12'hc00;
    mem.rom[3] = 12'h101;
    mem.rom[4] = 12'h3c1;
    mem.rom[5] = 12'hc55;
    mem.rom[6] = 12'h201;
    start();
    expect_state(8'hff, 8'h00, 11'h002, 1'b0);
    expect_state(8'hff, 8'h00, 11'h003, 1'b0);
    expect_state(8'h00, 8'h00, 11'h004, 1'b0);
    expect_state(8'hff, 8'h00, 11'h005, 1'b0);
    expect_state(8'h00, 8'h00, 11'h006, 1'b1);
    expect_state(8'h00, 8'h00, 11'h007, 1'b0);
    expect_state(8'hff, 8'h00, 11'h008, 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    page_load = 1'b0;
    page_value = 2'b00;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    test_literal();
    test_files();
    test_jump();
    test_acc_dest();
    final_report();
  end
endmodule
